/* File: rtl/csch_pkg.sv */
// Constants shared by both ends of the configuration status chain.
// Assumes one 200 MHz clock and active-low asynchronous reset per end.
// Contract
// RULE_01: Done flag held low through data transfer.
// RULE_02: Release done flag after clean data, init.
// RULE_03: Enter user mode only after done reads high.
// RULE_04: User mode ignores external done flag pulls.
// RULE_05: Accept configuration only while chain enable low.
// RULE_06: First device enabled; output feeds next input.
// RULE_07: Keep chain enable low during JTAG programming.
// RULE_08: Drive chain output low when configuration completes.
// RULE_09: Chain output becomes user I/O afterwards.
// RULE_10: Status low until power-on reset interval expires.
// RULE_11: Status release retriggers a failed early attempt.
// RULE_12: Error drives status low; external low errors.
// RULE_13: Reconfigure only by pulling request input low.
// RULE_14: Read back wired-AND line levels for decisions.
package csch_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int POR_TIME_NS = 1000;
    localparam int POR_CYCLES = POR_TIME_NS / CLK_PERIOD_NS;
    localparam int INIT_TIME_NS = 100;
    localparam int INIT_CYCLES = INIT_TIME_NS / CLK_PERIOD_NS;
    // Request low time; must outlast the far end's two-stage agreement
    localparam int REQ_HOLD_CYCLES = 4;
    localparam int CNT_W = 16;
    localparam logic [1:0] SYNC_ONES = 2'h3;
    localparam logic [1:0] SYNC_ZEROS = 2'h0;
    typedef enum logic [2:0] {
        CSCH_POR, CSCH_IDLE, CSCH_LOAD, CSCH_WAIT_DONE, CSCH_INIT,
        CSCH_USER, CSCH_ERROR
    } csch_state_e;
    typedef enum logic [1:0] {
        CSCH_H_IDLE, CSCH_H_SEND, CSCH_H_WAIT, CSCH_H_DONE
    } csch_host_state_e;
endpackage

/* File: rtl/csch_if.sv */
`timescale 1ns/1ps
// Wired-AND carrier for status, done and chain lines between two ends.
// Assumes external pull-ups: a line is high unless some end drives it.
interface csch_if;
    logic dev_status_oe_n;
    logic dev_done_oe_n;
    logic dev_chain_out_oe_n;
    logic dev_chain_out_o;
    logic host_status_oe_n;
    logic host_done_oe_n;
    logic host_config_request_n;
    logic host_chain_enable_in_n;
    logic status_line;
    logic done_line;
    logic chain_out_line;
    // Open-drain resolution; pull-ups make released lines high
    assign status_line = dev_status_oe_n & host_status_oe_n;
    assign done_line = dev_done_oe_n & host_done_oe_n;
    assign chain_out_line = dev_chain_out_oe_n | dev_chain_out_o;
    modport device (
        input status_line, done_line, host_config_request_n,
        input host_chain_enable_in_n,
        output dev_status_oe_n, dev_done_oe_n, dev_chain_out_oe_n,
        output dev_chain_out_o
    );
    modport host (
        input status_line, done_line, chain_out_line,
        output host_status_oe_n, host_done_oe_n, host_config_request_n,
        output host_chain_enable_in_n
    );
endinterface

/* File: rtl/csch_device.sv */
`timescale 1ns/1ps
// Target-device end: status, done and chain handshake of configuration.
// Assumes pins resolved by csch_if; data path is abstracted as strobes.
module csch_device #(
    parameter int POR_CYCLES = csch_pkg::POR_CYCLES,
    parameter int INIT_CYCLES = csch_pkg::INIT_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_data_last,
    input wire logic i_data_error,
    input wire logic i_user_io,
    input wire logic i_user_io_oe_n,
    output logic o_user_mode,
    output logic o_error,
    csch_if.device pins
);
    csch_pkg::csch_state_e state, next_state;
    logic [csch_pkg::CNT_W-1:0] cnt, next_cnt;
    logic [2:0] st_sync, dn_sync, cr_sync, ce_sync;
    logic status_in, done_in, cfg_req_in, ce_in;
    logic next_status_in, next_done_in, next_cfg_req_in, next_ce_in;
    logic status_oe_n, next_status_oe_n;
    logic done_oe_n, next_done_oe_n;
    logic chain_oe_n, next_chain_oe_n;
    logic chain_o, next_chain_o;
    logic next_user_mode, next_error;

    function automatic logic filt(input logic [2:0] s, input logic prev);
        if (s[2:1] == csch_pkg::SYNC_ONES) begin
            return 1'b1;
        end else if (s[2:1] == csch_pkg::SYNC_ZEROS) begin
            return 1'b0;
        end
        return prev;
    endfunction

    // Terminal count of a timed phase, shared by POR and INIT
    function automatic logic cnt_done(
        input logic [csch_pkg::CNT_W-1:0] c,
        input int limit
    );
        return c >= csch_pkg::CNT_W'(limit - 1);
    endfunction

    // Phase counters stop well short of the wrap point
    function automatic logic [csch_pkg::CNT_W-1:0] cnt_inc(
        input logic [csch_pkg::CNT_W-1:0] c
    );
        return c + 1'b1;
    endfunction

    // Three-stage sync; stage 0 only feeds stage 1
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_sync <= 3'h0;
            dn_sync <= 3'h0;
            cr_sync <= 3'h7;
            ce_sync <= 3'h7;
        end else if (i_ce) begin
            st_sync <= {st_sync[1:0], pins.status_line};
            dn_sync <= {dn_sync[1:0], pins.done_line};
            cr_sync <= {cr_sync[1:0], pins.host_config_request_n};
            ce_sync <= {ce_sync[1:0], pins.host_chain_enable_in_n};
        end
    end

    always_comb begin
        next_status_in = filt(st_sync, status_in); // RULE_14
        next_done_in = filt(dn_sync, done_in); // RULE_14
        next_cfg_req_in = filt(cr_sync, cfg_req_in);
        next_ce_in = filt(ce_sync, ce_in);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_in <= 1'b0;
            done_in <= 1'b0;
            cfg_req_in <= 1'b1;
            ce_in <= 1'b1;
        end else if (i_ce) begin
            status_in <= next_status_in;
            done_in <= next_done_in;
            cfg_req_in <= next_cfg_req_in;
            ce_in <= next_ce_in;
        end
    end

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_status_oe_n = status_oe_n;
        next_done_oe_n = done_oe_n;
        next_chain_oe_n = chain_oe_n;
        next_chain_o = chain_o;
        next_user_mode = 1'b0;
        next_error = o_error;
        unique case (state)
            csch_pkg::CSCH_POR: begin
                next_status_oe_n = 1'b0; // RULE_10
                next_done_oe_n = 1'b0; // RULE_01
                if (cnt_done(cnt, POR_CYCLES)) begin
                    // Release status; a failed early try restarts here
                    next_status_oe_n = 1'b1; // RULE_10 RULE_11
                    next_cnt = '0;
                    next_state = csch_pkg::CSCH_IDLE;
                end else begin
                    next_cnt = cnt_inc(cnt);
                end
            end
            csch_pkg::CSCH_IDLE: begin
                next_done_oe_n = 1'b0; // RULE_01
                next_chain_oe_n = 1'b1;
                // Start only once status reads high and chain enabled
                if (status_in && !ce_in && cfg_req_in) begin // RULE_05
                    next_state = csch_pkg::CSCH_LOAD;
                end
            end
            csch_pkg::CSCH_LOAD: begin
                next_done_oe_n = 1'b0; // RULE_01
                if (!status_in || ce_in || i_data_error) begin // RULE_12
                    next_status_oe_n = 1'b0;
                    next_error = 1'b1;
                    next_state = csch_pkg::CSCH_ERROR;
                end else if (i_data_last) begin
                    next_done_oe_n = 1'b1; // RULE_02
                    next_state = csch_pkg::CSCH_WAIT_DONE;
                end
            end
            csch_pkg::CSCH_WAIT_DONE: begin
                // Pin may be held low by others; read back level
                if (!status_in) begin // RULE_12
                    next_error = 1'b1;
                    next_state = csch_pkg::CSCH_ERROR;
                end else if (done_in) begin // RULE_03 RULE_14
                    next_cnt = '0;
                    next_chain_oe_n = 1'b0; // RULE_08
                    next_chain_o = 1'b0;
                    next_state = csch_pkg::CSCH_INIT;
                end
            end
            csch_pkg::CSCH_INIT: begin
                if (!status_in) begin // RULE_12
                    next_error = 1'b1;
                    next_state = csch_pkg::CSCH_ERROR;
                end else if (cnt_done(cnt, INIT_CYCLES)) begin
                    next_state = csch_pkg::CSCH_USER;
                    next_user_mode = 1'b1;
                end else begin
                    next_cnt = cnt_inc(cnt);
                end
            end
            csch_pkg::CSCH_USER: begin
                // Status and done pulls are ignored here
                next_user_mode = 1'b1; // RULE_04 RULE_13
                next_chain_oe_n = i_user_io_oe_n; // RULE_09
                next_chain_o = i_user_io; // RULE_09
            end
            csch_pkg::CSCH_ERROR: begin
                next_status_oe_n = 1'b0; // RULE_12
                next_done_oe_n = 1'b0;
                next_chain_oe_n = 1'b1;
            end
            default: next_state = csch_pkg::CSCH_POR;
        endcase
        // Request pulse restarts from any state after power-on reset
        if (!cfg_req_in && state != csch_pkg::CSCH_POR) begin // RULE_13
            next_state = csch_pkg::CSCH_IDLE;
            next_status_oe_n = 1'b0;
            next_done_oe_n = 1'b0;
            next_chain_oe_n = 1'b1;
            next_chain_o = 1'b1;
            next_user_mode = 1'b0;
            next_error = 1'b0;
        end else if (cfg_req_in && state == csch_pkg::CSCH_IDLE
                     && !status_oe_n) begin
            next_status_oe_n = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= csch_pkg::CSCH_POR;
            cnt <= '0;
            status_oe_n <= 1'b0;
            done_oe_n <= 1'b0;
            chain_oe_n <= 1'b1;
            chain_o <= 1'b1;
            o_user_mode <= 1'b0;
            o_error <= 1'b0;
        end else if (i_ce) begin
            state <= next_state;
            cnt <= next_cnt;
            status_oe_n <= next_status_oe_n;
            done_oe_n <= next_done_oe_n;
            chain_oe_n <= next_chain_oe_n;
            chain_o <= next_chain_o;
            o_user_mode <= next_user_mode;
            o_error <= next_error;
        end
    end

    assign pins.dev_status_oe_n = status_oe_n;
    assign pins.dev_done_oe_n = done_oe_n;
    assign pins.dev_chain_out_oe_n = chain_oe_n;
    assign pins.dev_chain_out_o = chain_o;
endmodule

/* File: rtl/csch_host.sv */
`timescale 1ns/1ps
// Host end: drives request and chain enable, watches status and done.
// Assumes lines resolved by csch_if with pull-ups.
module csch_host (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic i_force_error,
    output logic o_busy,
    output logic o_done,
    output logic o_status_low,
    csch_if.host pins
);
    csch_pkg::csch_host_state_e state, next_state;
    logic [2:0] st_sync, dn_sync;
    logic [2:0] hold, next_hold;
    logic req_n, next_req_n, err_oe_n, next_err_oe_n;
    logic next_busy, next_done, next_status_low;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_sync <= 3'h0;
            dn_sync <= 3'h0;
        end else if (i_ce) begin
            st_sync <= {st_sync[1:0], pins.status_line};
            dn_sync <= {dn_sync[1:0], pins.done_line};
        end
    end

    always_comb begin
        next_state = state;
        next_hold = hold;
        next_req_n = 1'b1;
        next_err_oe_n = !i_force_error; // RULE_12
        next_status_low = (st_sync[2:1] == csch_pkg::SYNC_ZEROS);
        next_done = o_done;
        unique case (state)
            csch_pkg::CSCH_H_IDLE: if (i_start) begin
                next_req_n = 1'b0; // RULE_13
                next_done = 1'b0;
                next_hold = '0;
                next_state = csch_pkg::CSCH_H_SEND;
            end
            // A one-cycle pulse would vanish in the far input filter
            csch_pkg::CSCH_H_SEND: begin
                if (hold < 3'(csch_pkg::REQ_HOLD_CYCLES - 1)) begin
                    next_req_n = 1'b0; // RULE_13
                    next_hold = hold + 1'b1;
                end else if (dn_sync[2:1] == csch_pkg::SYNC_ZEROS) begin
                    // Stale high done would otherwise end the wait early
                    next_state = csch_pkg::CSCH_H_WAIT;
                end
            end
            // A failed load never raises done; a new start ends the wait
            csch_pkg::CSCH_H_WAIT: begin
                if (i_start) begin
                    next_req_n = 1'b0; // RULE_13
                    next_done = 1'b0;
                    next_hold = '0;
                    next_state = csch_pkg::CSCH_H_SEND;
                end else if (dn_sync[2:1] == csch_pkg::SYNC_ONES) begin
                    next_done = 1'b1;
                    next_state = csch_pkg::CSCH_H_DONE;
                end
            end
            csch_pkg::CSCH_H_DONE: next_state = csch_pkg::CSCH_H_IDLE;
        endcase
        next_busy = (next_state != csch_pkg::CSCH_H_IDLE);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= csch_pkg::CSCH_H_IDLE;
            hold <= 3'h0;
            req_n <= 1'b1;
            err_oe_n <= 1'b1;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_status_low <= 1'b0;
        end else if (i_ce) begin
            state <= next_state;
            hold <= next_hold;
            req_n <= next_req_n;
            err_oe_n <= next_err_oe_n;
            o_busy <= next_busy;
            o_done <= next_done;
            o_status_low <= next_status_low;
        end
    end

    assign pins.host_status_oe_n = err_oe_n;
    assign pins.host_done_oe_n = 1'b1;
    assign pins.host_config_request_n = req_n;
    // First device of chain: enable tied low, also for JTAG
    assign pins.host_chain_enable_in_n = 1'b0; // RULE_05 RULE_06 RULE_07
endmodule

/* File: verification/csch_chk.sv */
`timescale 1ns/1ps
// Concurrent checks on the lines between device and host ends.
// Assumes clock enables stay high and the bench connects it by name.
module csch_chk #(
    parameter int POR_CYCLES = 8,
    parameter int INIT_CYCLES = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic dev_status_oe_n,
    input wire logic dev_done_oe_n,
    input wire logic dev_chain_out_oe_n,
    input wire logic host_status_oe_n,
    input wire logic host_config_request_n,
    input wire logic host_chain_enable_in_n,
    input wire logic done_line,
    input wire logic chain_out_line
);
    logic [15:0] por_cnt;
    logic [15:0] rel_cnt;
    logic [3:0] req_cnt;
    logic [15:0] next_por_cnt;
    logic [15:0] next_rel_cnt;
    logic [3:0] next_req_cnt;
    // Saturating counts so long user mode never wraps back into POR
    always_comb begin
        next_por_cnt = (&por_cnt) ? por_cnt : por_cnt + 16'h1;
        next_rel_cnt = !dev_done_oe_n ? 16'h0 :
            ((&rel_cnt) ? rel_cnt : rel_cnt + 16'h1);
        next_req_cnt = !host_config_request_n ? 4'h0 :
            ((&req_cnt) ? req_cnt : req_cnt + 4'h1);
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            por_cnt <= 16'h0;
            rel_cnt <= 16'h0;
            req_cnt <= 4'hF;
        end else begin
            por_cnt <= next_por_cnt;
            rel_cnt <= next_rel_cnt;
            req_cnt <= next_req_cnt;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    a_por_status_low: assert property (
        int'(por_cnt) < POR_CYCLES - 1 |-> !dev_status_oe_n)
        else $error("status released before POR interval");
    a_por_status_rel: assert property (
        int'(por_cnt) == POR_CYCLES + 8 |-> dev_status_oe_n)
        else $error("status still driven after POR interval");
    a_por_done_low: assert property (
        int'(por_cnt) < POR_CYCLES + 2 |-> !dev_done_oe_n)
        else $error("done released before configuration");
    a_chain_after_done: assert property (
        $fell(dev_chain_out_oe_n) |-> done_line && $past(done_line, 2))
        else $error("chain enabled without done line high");
    a_chain_off_config: assert property (
        !dev_done_oe_n |-> chain_out_line)
        else $error("chain driven low while done held low");
    a_request_restart: assert property (
        $fell(host_config_request_n) |=> !host_config_request_n [*3]
        ##1 host_config_request_n ##[0:7] !dev_done_oe_n)
        else $error("request did not restart configuration");
    a_user_done_held: assert property (
        dev_done_oe_n && int'(rel_cnt) > INIT_CYCLES + 16 &&
        req_cnt > 4'h8 |=> dev_done_oe_n)
        else $error("done dropped in user mode without request");
    a_chain_enable_low: assert property (
        host_chain_enable_in_n == 1'h0 && $stable(host_chain_enable_in_n))
        else $error("chain enable input not held low");
endmodule

/* File: verification/config_status_chain_handshake_tb_top.sv */
`timescale 1ns/1ps
// Bench joining device and host ends through one csch_if.
// Assumes shortened POR and INIT counts to keep the run brief.
module config_status_chain_handshake_tb_top;
    logic i_clk = 1'h0;
    logic i_rst_n = 1'h0;
    logic ce = 1'h1, last = 1'h0, derr = 1'h0, uio = 1'h0, uio_oe_n = 1'h1;
    logic start = 1'h0, force_err = 1'h0;
    logic user_mode, dev_err, busy, hdone, st_low;
    int error_cnt = 0, tests_run = 0, seed = 1364, i;
    always #2.5 i_clk = ~i_clk;
    csch_if pins_if();
    csch_device #(.POR_CYCLES(8), .INIT_CYCLES(4)) u_csch_device (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_data_last(last),
        .i_data_error(derr), .i_user_io(uio), .i_user_io_oe_n(uio_oe_n),
        .o_user_mode(user_mode), .o_error(dev_err), .pins(pins_if.device));
    csch_host u_csch_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
        .i_start(start), .i_force_error(force_err), .o_busy(busy),
        .o_done(hdone), .o_status_low(st_low), .pins(pins_if.host));
    csch_chk #(.POR_CYCLES(8), .INIT_CYCLES(4)) u_csch_chk (
        .i_clk(i_clk), .i_rst_n(i_rst_n),
        .dev_status_oe_n(pins_if.dev_status_oe_n),
        .dev_done_oe_n(pins_if.dev_done_oe_n),
        .dev_chain_out_oe_n(pins_if.dev_chain_out_oe_n),
        .host_status_oe_n(pins_if.host_status_oe_n),
        .host_config_request_n(pins_if.host_config_request_n),
        .host_chain_enable_in_n(pins_if.host_chain_enable_in_n),
        .done_line(pins_if.done_line),
        .chain_out_line(pins_if.chain_out_line));
    task automatic chk(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("counts: tests=%0d errors=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Bounded wait: 0 status line, 1 user mode, 2 device error
    task automatic wait_for(input int sel, input logic want);
        logic v;
        for (int k = 0; k < 400; k++) begin
            @(negedge i_clk);
            v = sel == 0 ? pins_if.status_line
                : (sel == 1 ? user_mode : dev_err);
            if (v === want) return;
        end
        error_cnt++;
        $display("BAD t=%0t wait=%h want=%h", $time, sel, want);
        complete_run();
    endtask
    task automatic pulse(input int sel);
        @(posedge i_clk);
        if (sel == 0) start <= 1'h1; else if (sel == 1) last <= 1'h1;
        else derr <= 1'h1;
        @(posedge i_clk);
        start <= 1'h0; last <= 1'h0; derr <= 1'h0;
    endtask
    function automatic logic exp_err(input int kind);
        return kind != 0;
    endfunction
    // Kind 0 clean load, 1 data error, 2 status pulled low by host
    task automatic cfg_round(input int kind);
        step(10);
        @(negedge i_clk) chk(pins_if.done_line, 1'h0);
        if (kind == 2) begin
            @(posedge i_clk) force_err <= 1'h1;
            step(4);
            force_err <= 1'h0;
        end else pulse(kind == 0 ? 1 : 2);
        wait_for(kind == 0 ? 1 : 2, 1'h1);
        chk(dev_err, exp_err(kind));
        chk(pins_if.status_line, !exp_err(kind));
        chk(pins_if.done_line, !exp_err(kind));
        chk(pins_if.chain_out_line, exp_err(kind));
        step(4);
        @(negedge i_clk) chk(st_low, exp_err(kind));
        chk(busy, exp_err(kind));
        if (kind == 0) begin
            chk(hdone, 1'h1);
            @(posedge i_clk) force_err <= 1'h1;
            step(6);
            force_err <= 1'h0;
            @(negedge i_clk) chk(user_mode, 1'h1);
            chk(dev_err, 1'h0);
            @(posedge i_clk) uio_oe_n <= 1'h0;
            for (int k = 0; k < 6; k++) begin
                @(posedge i_clk) uio <= 1'($random(seed));
                step(4);
                @(negedge i_clk) chk(pins_if.chain_out_line, uio);
            end
            @(posedge i_clk) uio_oe_n <= 1'h1;
        end
        pulse(0);
        wait_for(2, 1'h0);
        wait_for(1, 1'h0);
        chk(pins_if.done_line, 1'h0);
        wait_for(0, 1'h1);
        $display("round kind=%0d finished", kind);
    endtask
    initial begin
        step(6);
        i_rst_n <= 1'h1;
        @(negedge i_clk) chk(pins_if.status_line, 1'h0);
        chk(pins_if.done_line, 1'h0);
        chk(pins_if.chain_out_line, 1'h1);
        // Host must request once so its done tracking is armed
        pulse(0);
        step(12);
        wait_for(0, 1'h1);
        for (i = 0; i < 3; i++) cfg_round(i);
        for (i = 0; i < 5; i++) cfg_round($unsigned($random(seed)) % 3);
        cfg_round(0);
        @(posedge i_clk) i_rst_n <= 1'h0;
        step(2);
        @(negedge i_clk) chk(user_mode, 1'h0);
        chk(pins_if.status_line, 1'h0);
        @(posedge i_clk) i_rst_n <= 1'h1;
        pulse(0);
        step(12);
        wait_for(0, 1'h1);
        cfg_round(0);
        complete_run();
    end
endmodule
